// ===== shared/bus_cycle_pkg.sv
package bus_cycle_pkg;
   localparam logic [2:0] CYC_MEM_WRITE = 3'h1;
   localparam logic [2:0] CYC_MEM_READ  = 3'h2;
   localparam logic [2:0] CYC_IO_WRITE  = 3'h5;
   localparam logic [2:0] CYC_IO_READ   = 3'h6;
   localparam logic [2:0] CYC_FETCH     = 3'h3;
   localparam logic [2:0] CYC_INTA      = 3'h7;
   localparam logic [2:0] CYC_HALT      = 3'h0;
   localparam logic [7:0] DATA_RESET    = 8'h00;
   localparam logic [15:0] ADDR_RESET   = 16'h0000;
   typedef enum logic [2:0] {
      ST_IDLE, ST_T1, ST_T2, ST_TW, ST_T3, ST_HOLD, ST_HALT, ST_RESUME
   } bus_state_e;
endpackage

// ===== rtl/sync2.sv
`timescale 1ns/10ps
module sync2 (
   input  wire logic sys_clk_in,
   input  wire logic rstn_in,
   input  wire logic async_in,
   output logic      sync_out
);
   logic meta_q;
   logic meta_d;
   logic sync_q;
   logic sync_d;
   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
      if (!rstn_in) begin
         meta_d = 1'b0;
         sync_d = 1'b0;
      end
   end
   always_ff @(posedge sys_clk_in) begin
      meta_q <= meta_d;
      sync_q <= sync_d;
   end
   assign sync_out = sync_q;
endmodule // sync2

// ===== rtl/bus_master_cycle.sv
`timescale 1ns/10ps
module bus_master_cycle
   import bus_cycle_pkg::*;
(
   input  wire logic        sys_clk_in,
   input  wire logic        rstn_in,
   input  wire logic        req_valid_in,
   input  wire logic [2:0]  req_kind_in,
   input  wire logic [15:0] req_addr_in,
   input  wire logic [7:0]  req_wdata_in,
   input  wire logic        halt_in,
   output logic             req_ready_out,
   output logic             done_out,
   output logic [7:0]       rdata_out,
   input  wire logic [7:0]  shared_addr_data_in,
   output logic [7:0]       shared_addr_data_out,
   output logic             shared_addr_data_oe_out,
   output logic [7:0]       upper_address_out,
   output logic             upper_address_oe_out,
   output logic             addr_latch_out,
   output logic             io_mem_out,
   output logic             io_mem_oe_out,
   output logic             cycle_status_hi_out,
   output logic             cycle_status_lo_out,
   output logic             read_n_out,
   output logic             write_n_out,
   output logic             strobe_oe_out,
   input  wire logic        ready_in,
   input  wire logic        hold_req_in,
   output logic             hold_acknowledge_out
);
   logic       ready_s;
   logic       hold_s;
   bus_state_e st_q, st_d;
   logic [2:0] kind_q, kind_d;
   logic [7:0] wd_q, wd_d;
   logic [7:0] rd_q, rd_d;
   logic       done_q, done_d;
   logic       rdy_q, rdy_d;
   logic [7:0] ad_q, ad_d;
   logic       ad_oe_q, ad_oe_d;
   logic [7:0] ua_q, ua_d;
   logic       ua_oe_q, ua_oe_d;
   logic       ale_q, ale_d;
   logic [2:0] stat_q, stat_d;
   logic       iom_oe_q, iom_oe_d;
   logic       rdn_q, rdn_d;
   logic       wrn_q, wrn_d;
   logic       stb_oe_q, stb_oe_d;
   logic       hold_acknowledge_q, hold_acknowledge_d;
   logic       is_write;

   sync2 u_ready (
      .sys_clk_in (sys_clk_in),
      .rstn_in    (rstn_in),
      .async_in   (ready_in),
      .sync_out   (ready_s)
   );
   sync2 u_hold (
      .sys_clk_in (sys_clk_in),
      .rstn_in    (rstn_in),
      .async_in   (hold_req_in),
      .sync_out   (hold_s)
   );

   assign is_write = (kind_q == CYC_MEM_WRITE) || (kind_q == CYC_IO_WRITE);

   always_comb begin
      st_d = st_q;
      kind_d = kind_q;
      wd_d = wd_q;
      rd_d = rd_q;
      done_d = 1'b0;
      rdy_d = 1'b0;
      ad_d = ad_q;
      ad_oe_d = 1'b0;
      ua_d = ua_q;
      ua_oe_d = ua_oe_q;
      ale_d = 1'b0;
      stat_d = stat_q;
      iom_oe_d = iom_oe_q;
      rdn_d = 1'b1;
      wrn_d = 1'b1;
      stb_oe_d = stb_oe_q;
      hold_acknowledge_d = hold_acknowledge_q;
      case (st_q)
         ST_IDLE: begin
            if (hold_s) begin
               hold_acknowledge_d = 1'b1;
               st_d = ST_HOLD;
            end else if (halt_in) begin
               st_d = ST_HALT;
            end else if (req_valid_in) begin
               kind_d = req_kind_in;
               wd_d = req_wdata_in;
               st_d = ST_T1;
               stat_d = req_kind_in;
               ua_d = req_addr_in[15:8];
               ad_d = req_addr_in[7:0];
               ad_oe_d = 1'b1;
               ale_d = 1'b1;
               ua_oe_d = 1'b1;
               iom_oe_d = 1'b1;
               stb_oe_d = 1'b1;
            end else begin
               rdy_d = 1'b1;
            end
         end
         ST_T1: begin
            st_d = ST_T2;
            ad_oe_d = is_write;
            ad_d = wd_q;
            rdn_d = is_write;
            wrn_d = !is_write;
         end
         ST_T2, ST_TW: begin
            ad_oe_d = is_write;
            rdn_d = is_write;
            wrn_d = !is_write;
            if (ready_s) begin
               st_d = ST_T3;
            end else begin
               st_d = ST_TW;
            end
            if (is_write && ready_s) begin
               wrn_d = 1'b1;
            end
            if (!is_write && ready_s) begin
               rd_d = shared_addr_data_in;
               rdn_d = 1'b1;
            end
         end
         ST_T3: begin
            ad_oe_d = 1'b0;
            done_d = 1'b1;
            st_d = ST_IDLE;
            rdy_d = !hold_s;
            if (hold_s) begin
               hold_acknowledge_d = 1'b1;
               st_d = ST_HOLD;
            end
         end
         ST_HOLD: begin
            ua_oe_d = 1'b0;
            iom_oe_d = 1'b0;
            stb_oe_d = 1'b0;
            if (!hold_s) begin
               hold_acknowledge_d = 1'b0;
               st_d = ST_RESUME;
            end
         end
         ST_RESUME: begin
            ua_oe_d = 1'b1;
            iom_oe_d = 1'b1;
            stb_oe_d = 1'b1;
            st_d = ST_IDLE;
            rdy_d = 1'b1;
         end
         ST_HALT: begin
            stat_d = CYC_HALT;
            ua_oe_d = 1'b0;
            iom_oe_d = 1'b0;
            stb_oe_d = 1'b0;
            if (hold_s) begin
               hold_acknowledge_d = 1'b1;
               st_d = ST_HOLD;
            end else if (!halt_in) begin
               st_d = ST_RESUME;
            end
         end
         default: st_d = ST_IDLE;
      endcase
      if (!rstn_in) begin
         st_d = ST_IDLE;
         kind_d = CYC_HALT;
         wd_d = DATA_RESET;
         rd_d = DATA_RESET;
         done_d = 1'b0;
         rdy_d = 1'b0;
         ad_d = DATA_RESET;
         ad_oe_d = 1'b0;
         ua_d = DATA_RESET;
         ua_oe_d = 1'b0;
         ale_d = 1'b0;
         stat_d = CYC_HALT;
         iom_oe_d = 1'b0;
         rdn_d = 1'b1;
         wrn_d = 1'b1;
         stb_oe_d = 1'b0;
         hold_acknowledge_d = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      st_q <= st_d;
      kind_q <= kind_d;
      wd_q <= wd_d;
      rd_q <= rd_d;
      done_q <= done_d;
      rdy_q <= rdy_d;
      ad_q <= ad_d;
      ad_oe_q <= ad_oe_d;
      ua_q <= ua_d;
      ua_oe_q <= ua_oe_d;
      ale_q <= ale_d;
      stat_q <= stat_d;
      iom_oe_q <= iom_oe_d;
      rdn_q <= rdn_d;
      wrn_q <= wrn_d;
      stb_oe_q <= stb_oe_d;
      hold_acknowledge_q <= hold_acknowledge_d;
   end

   assign req_ready_out = rdy_q;
   assign done_out = done_q;
   assign rdata_out = rd_q;
   assign shared_addr_data_out = ad_q;
   assign shared_addr_data_oe_out = ad_oe_q;
   assign upper_address_out = ua_q;
   assign upper_address_oe_out = ua_oe_q;
   assign addr_latch_out = ale_q;
   assign io_mem_out = stat_q[2];
   assign io_mem_oe_out = iom_oe_q;
   assign cycle_status_hi_out = stat_q[1];
   assign cycle_status_lo_out = stat_q[0];
   assign read_n_out = rdn_q;
   assign write_n_out = wrn_q;
   assign strobe_oe_out = stb_oe_q;
   assign hold_acknowledge_out = hold_acknowledge_q;
endmodule // bus_master_cycle

// ===== verif/bus_master_cycle_monitor.sv
`timescale 1ns/10ps
module bus_master_cycle_monitor (
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic done_out,
   input wire logic shared_addr_data_oe_out,
   input wire logic upper_address_oe_out,
   input wire logic addr_latch_out,
   input wire logic strobe_oe_out,
   input wire logic read_n_out,
   input wire logic write_n_out,
   input wire logic hold_acknowledge_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rstn_in);
   sequence s_no_done;
      !done_out [*2];
   endsequence
   a_ale_pulse: assert property (
      addr_latch_out |=> !addr_latch_out) else $error("ale wide");
   a_ale_drives: assert property (
      addr_latch_out |-> shared_addr_data_oe_out && upper_address_oe_out)
      else $error("address not driven");
   a_cycle_len: assert property (
      addr_latch_out |=> s_no_done ##[1:60] done_out) else $error("length");
   a_t2_data: assert property (
      addr_latch_out |=> !shared_addr_data_oe_out || !write_n_out)
      else $error("t2 data");
   a_read_float: assert property (
      strobe_oe_out && !read_n_out |-> !shared_addr_data_oe_out)
      else $error("read drives");
   a_write_data: assert property (
      strobe_oe_out && !write_n_out |=> shared_addr_data_oe_out)
      else $error("write data");
   a_hold_float: assert property (
      $rose(hold_acknowledge_out) |=> !(strobe_oe_out
      || upper_address_oe_out || shared_addr_data_oe_out)) else $error("hold");
   a_hold_keep: assert property (
      hold_acknowledge_out |-> !addr_latch_out) else $error("retake");
endmodule // bus_master_cycle_monitor
bind bus_master_cycle bus_master_cycle_monitor mon_inst (.*);

// ===== verif/bus_slave_model.sv
`timescale 1ns/10ps
module bus_slave_model (
   input  wire logic       clk_in,
   input  wire logic       ale_in,
   input  wire logic [7:0] dut_ad_in,
   input  wire logic       ad_oe_in,
   input  wire logic       rd_n_in,
   input  wire logic       wr_n_in,
   input  wire logic       st_oe_in,
   input  wire logic [1:0] waits_in,
   output logic      [7:0] bus_out,
   output logic            ready_out
);
   logic [7:0] mem [256];
   logic [7:0] a_q = 8'h00, last_q = 8'h00;
   int         cnt_q = 0;
   wire        act = st_oe_in && !(rd_n_in && wr_n_in);
   initial foreach (mem[i]) mem[i] = 8'h00;
   // mid-cycle sampling keeps clear of the launching edge
   always @(negedge clk_in) begin
      if (ale_in) a_q <= dut_ad_in;
      if (act && !wr_n_in) mem[a_q] <= dut_ad_in;
      cnt_q <= act ? cnt_q + 1 : 0;
      last_q <= bus_out;
   end
   assign ready_out = waits_in == 2'h0 || cnt_q >= waits_in;
   // released lines show the inverse of the last level
   assign bus_out = ad_oe_in ? dut_ad_in
                  : (act && !rd_n_in) ? mem[a_q] : ~last_q;
endmodule // bus_slave_model

// ===== verif/bus_master_cycle_tb.sv
`timescale 1ns/10ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin num_errors++; \
$display("BAD %0t mismatch %h %h", $time, a, e); end end
module bus_master_cycle_tb;
   import bus_cycle_pkg::*;
   logic sys_clk_in = 0, rstn_in = 0, req_valid_in = 0, halt_in = 0;
   logic hold_req_in = 0, ready_in, req_ready_out, done_out, addr_latch_out;
   logic shared_addr_data_oe_out, upper_address_oe_out, io_mem_out;
   logic io_mem_oe_out, cycle_status_hi_out, cycle_status_lo_out;
   logic read_n_out, write_n_out, strobe_oe_out, hold_acknowledge_out;
   logic [2:0] req_kind_in = 3'h0;
   logic [15:0] req_addr_in = 16'h0000, lf = 16'h002f;
   logic [7:0] req_wdata_in = 8'h00, rdata_out, shared_addr_data_in;
   logic [7:0] shared_addr_data_out, upper_address_out, ref_mem [256];
   logic [1:0] waits = 2'h0;
   logic [2:0] kinds [6] = '{CYC_MEM_WRITE, CYC_MEM_READ, CYC_IO_WRITE,
                             CYC_IO_READ, CYC_FETCH, CYC_INTA};
   wire [2:0]  stat_w = {io_mem_out, cycle_status_hi_out,
                         cycle_status_lo_out};
   wire [3:0]  oe_w = {shared_addr_data_oe_out, upper_address_oe_out,
                       strobe_oe_out, io_mem_oe_out};
   wire [15:0] addr_w = {upper_address_out, shared_addr_data_in};
   int num_errors = 0, n_tests = 0, i;
   bus_master_cycle bus_master_cycle_inst (.*);
   bus_slave_model bus_slave_model_inst (.clk_in(sys_clk_in),
      .ale_in(addr_latch_out), .dut_ad_in(shared_addr_data_out),
      .ad_oe_in(shared_addr_data_oe_out), .rd_n_in(read_n_out),
      .wr_n_in(write_n_out), .st_oe_in(strobe_oe_out), .waits_in(waits),
      .bus_out(shared_addr_data_in), .ready_out(ready_in));
   function automatic logic [15:0] lfsr(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic test_done();
      if (num_errors == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic xfer(logic [2:0] k, logic [15:0] a, logic [7:0] d,
                       logic [1:0] w);
      int n;
      int exp_n;
      n = 0;
      // three t states; synchronised ready makes w strobe cycles w+1 waits
      exp_n = (w == 2'h0) ? 3 : 4 + w;
      @(negedge sys_clk_in);
      {req_valid_in, req_kind_in, req_addr_in, req_wdata_in} = {1'b1, k, a, d};
      waits = w;
      while (!req_ready_out) @(negedge sys_clk_in);
      @(negedge sys_clk_in);
      req_valid_in = 0;
      `CHK(req_ready_out, 1'b0)
      while (!done_out && n < 40) begin
         if (addr_latch_out) begin
            `CHK(stat_w, k)
            `CHK(addr_w, a)
         end
         n++;
         @(negedge sys_clk_in);
      end
      `CHK({done_out, n == exp_n}, 2'h3)
      if (k == CYC_MEM_WRITE || k == CYC_IO_WRITE) ref_mem[a[7:0]] = d;
      else if (k != CYC_INTA) `CHK(rdata_out, ref_mem[a[7:0]])
   endtask
   initial forever #50 sys_clk_in = ~sys_clk_in;
   initial begin
      #200000;
      num_errors++;
      test_done();
   end
   initial begin
      foreach (ref_mem[j]) ref_mem[j] = 8'h00;
      repeat (3) @(negedge sys_clk_in);
      rstn_in = 1;
      `CHK(oe_w, 4'h0)
      for (i = 0; i < 36; i++) begin
         lf = lfsr(lf);
         xfer(kinds[i % 6], (i % 6 == 2 || i % 6 == 3) ? {2{5'h00, lf[2:0]}}
              : {lf[15:8], 5'h00, lf[2:0]}, lf[15:8], lf[9:8]);
      end
      fork
         xfer(CYC_MEM_READ, 16'h1203, 8'h00, 2'h2);
         begin
            repeat (3) @(negedge sys_clk_in);
            hold_req_in = 1;
            // hold seen while the transfer still waits on ready
            repeat (3) @(negedge sys_clk_in);
            `CHK(hold_acknowledge_out, 1'b0)
         end
      join
      `CHK(hold_acknowledge_out, 1'b1)
      for (i = 0; i < 10 && !hold_acknowledge_out; i++) @(negedge sys_clk_in);
      @(negedge sys_clk_in);
      `CHK({hold_acknowledge_out, oe_w}, 5'h10)
      req_valid_in = 1;
      repeat (5) begin
         @(negedge sys_clk_in);
         `CHK(addr_latch_out, 1'b0)
      end
      req_valid_in = 0;
      hold_req_in = 0;
      for (i = 0; i < 10 && hold_acknowledge_out; i++) @(negedge sys_clk_in);
      `CHK(hold_acknowledge_out, 1'b0)
      @(negedge sys_clk_in);
      `CHK(oe_w, 4'h7)
      xfer(CYC_MEM_READ, 16'h1203, 8'h00, 2'h1);
      halt_in = 1;
      repeat (4) @(negedge sys_clk_in);
      `CHK({oe_w, stat_w[1:0]}, 6'h00)
      test_done();
   end
endmodule // bus_master_cycle_tb
